/* include/osp_pkg.sv */
// Purpose: shared constants and types for the oscillator source and pll select block
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes:   divider fields sit at their clock divisor register positions

package osp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLOCK_DIVISOR_REGISTER_ADDR      = 8'h00;
  localparam logic [7:0]  FEEDBACK_ADDR    = 8'h04;
  localparam logic [7:0]  STATUS_ADDR      = 8'h08;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          RCPOST_LSB       = 8;
  localparam int          VCOPOST_LSB      = 6;
  localparam int          PRE_LSB          = 0;
  localparam int          STAT_SRC_LSB     = 12;
  localparam int          STAT_PMODE_LSB   = 8;
  localparam int          STAT_PIN_BIT     = 4;
  localparam int          STAT_PLL_BIT     = 0;
  localparam logic [2:0]  RCPOST_RESET     = 3'h0;
  localparam logic [1:0]  VCOPOST_RESET    = 2'h1;
  localparam logic [4:0]  PRE_RESET        = 5'h00;
  localparam logic [8:0]  FEEDBACK_RESET   = 9'h000;
  localparam logic [2:0]  ERASED_SOURCE    = 3'h7;
  localparam logic [1:0]  ERASED_PMODE     = 2'h3;

  // ----------------------------------------------------------------
  // factor offsets and fixed divides
  // ----------------------------------------------------------------
  localparam logic [5:0]  PRE_OFFSET       = 6'h02;
  localparam logic [9:0]  FEEDBACK_OFFSET  = 10'h002;
  localparam logic [8:0]  RC_DIV16         = 9'h010;
  localparam logic [1:0]  FOSC_TO_FCY      = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSP_SRC_FAST_RC     = 3'h0,
    OSP_SRC_RC_PLL      = 3'h1,
    OSP_SRC_PRIMARY     = 3'h2,
    OSP_SRC_PRIMARY_PLL = 3'h3,
    OSP_SRC_SECONDARY   = 3'h4,
    OSP_SRC_SLOW_RC     = 3'h5,
    OSP_SRC_RC_DIV16    = 3'h6,
    OSP_SRC_RC_DIVN     = 3'h7
  } osp_source_t;

  typedef enum logic [1:0] {
    OSP_PM_EXTERNAL = 2'h0,
    OSP_PM_STANDARD = 2'h1,
    OSP_PM_FAST     = 2'h2,
    OSP_PM_OFF      = 2'h3
  } osp_pmode_t;

  typedef struct packed {
    logic [2:0] rc_postscaler_field;
    logic [1:0] vco_output_postscaler_field;
    logic [4:0] vco_input_prescaler_field;
  } osp_clock_divisor_register_t;

endpackage

/* rtl/osp_clock_select.sv */
// Purpose: power-on source selection, rc postscaler, pll rate model and fosc/2
// Assumes: oscillators arrive as slow asynchronous levels; each rising edge becomes a tick
// Notes:   all derived clocks are one-cycle enables on hclk
//
// The register offsets and the AHB-Lite slave port were left to the implementer.

`timescale 1ns/1ps

// Behaviour
// R1: at reset release, source comes from 3-bit source and 2-bit primary mode straps.
// R2: source code 111..000 selects divn rc, rc/16, slow rc, secondary, primary pll, primary, rc pll, rc.
// R3: primary mode 10 fast crystal, 01 standard crystal, 00 external clock input.
// R4: erased device starts in rc with programmable divide, code 111.
// R5: oscillator or pll output divided by two gives instruction and peripheral ticks.
// R6: instruction rate up to 50 MIPS is supported.
// R7: rc clock divided by software postscale 1 to 256 from three-bit field.
// R8: pll source divided by input prescale 2 to 33 from five-bit field.
// R9: vco input multiplied by feedback factor from nine-bit field.
// R10: vco output divided by 2, 4 or 8 from bits 7:6.
// R11: pll output equals source times feedback over prescale times postscale.
// R12: software keeps vco input between 0.8 and 8 MHz.
// R13: software keeps vco output between 100 and 200 MHz.
// R14: software keeps pll output between 12.5 and 100 MHz.
// R15: only fast rc and primary clocks may pass the pll.
// R16: slow rc clock supplied as watchdog and monitor reference.
// R17: second oscillator pin function follows config bit in rc, slow rc, external modes.
// R18: postscaler 00 div2, 01 div4 default, 11 div8, 10 reserved.
// R19: prescaler 00000 div2 default up to 11111 div33.
// R20: rc postscaler 000..111 divide 1,2,4,8,16,32,64,256, default 1.
module osp_clock_select (
  input  wire logic        hclk,                      // system clock, 100 MHz
  input  wire logic        hresetn,                   // async reset, active low
  input  wire logic        hsel,                      // slave select
  input  wire logic [31:0] haddr,                     // byte address
  input  wire logic [1:0]  htrans,                    // transfer type
  input  wire logic        hwrite,                    // write when high
  input  wire logic [2:0]  hsize,                     // word transfers only
  input  wire logic [31:0] hwdata,                    // write data
  input  wire logic        hready,                    // bus ready in
  output logic      [31:0] hrdata,                    // read data
  output logic             hreadyout,                 // always ready
  output logic             hresp,                     // always okay
  input  wire logic [2:0]  initial_source_select,     // strap
  input  wire logic [1:0]  primary_mode_select,       // strap
  input  wire logic        second_pin_function_bit,   // strap
  input  wire logic        fast_internal_rc,          // rc oscillator level
  input  wire logic        primary_osc,               // primary oscillator level
  input  wire logic        secondary_crystal,         // secondary oscillator level
  input  wire logic        slow_internal_rc,          // slow rc oscillator level
  output logic             osc_tick,                  // oscillator output enable
  output logic             instr_tick,                // instruction clock enable
  output logic             peripheral_time_base,      // peripheral clock enable
  output logic             wdt_ref_tick,              // slow rc reference enable
  output logic             fast_crystal_drive,        // fast crystal driver on
  output logic             standard_crystal_drive,    // standard crystal driver on
  output logic             external_clock_input,      // primary pin is a clock input
  output logic             second_pin_is_io,          // second oscillator pin as i/o
  output logic             pll_active                 // pll in the clock path
);

  // ----------------------------------------------------------------
  // input synchronisers and edge ticks
  // ----------------------------------------------------------------
  logic [3:0] osc_meta;
  logic [3:0] osc_sync;
  logic [3:0] osc_last;
  wire  [3:0] osc_raw  = {slow_internal_rc, secondary_crystal, primary_osc, fast_internal_rc};
  wire  [3:0] osc_rise = osc_sync & ~osc_last;
  wire        rc_tick   = osc_rise[0];
  wire        prim_tick = osc_rise[1];
  wire        sec_tick  = osc_rise[2];
  wire        slow_tick = osc_rise[3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_meta <= 4'h0;
      osc_sync <= 4'h0;
      osc_last <= 4'h0;
    end else begin
      osc_meta <= osc_raw;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  // ----------------------------------------------------------------
  // power-on strap capture
  // ----------------------------------------------------------------
  logic        straps_taken;
  osp_pkg::osp_source_t cur_source;
  logic [1:0]  cur_pmode;
  logic        pin_fn;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps_taken <= 1'b0;
      cur_source   <= osp_pkg::osp_source_t'(osp_pkg::ERASED_SOURCE); // R4
      cur_pmode    <= osp_pkg::ERASED_PMODE;
      pin_fn       <= 1'b0;
    end else if (!straps_taken) begin
      straps_taken <= 1'b1;
      cur_source   <= osp_pkg::osp_source_t'(initial_source_select); // R1
      cur_pmode    <= primary_mode_select;                           // R1
      pin_fn       <= second_pin_function_bit;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  osp_pkg::osp_clock_divisor_register_t clock_divisor_register;
  osp_pkg::osp_clock_divisor_register_t next_clock_divisor_register;
  logic [8:0]  feedback;
  logic [8:0]  next_feedback;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  wire        addr_ok   = hsel && htrans[1] && hready;
  wire        wr_clock_divisor_register = wr_pend && (wr_addr == osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR);
  wire        wr_fbk    = wr_pend && (wr_addr == osp_pkg::FEEDBACK_ADDR);
  wire [7:0]  rd_addr   = haddr[7:0];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  assign next_clock_divisor_register   = wr_clock_divisor_register ? osp_pkg::osp_clock_divisor_register_t'({hwdata[10:8], hwdata[7:6],
                                                             hwdata[4:0]}) : clock_divisor_register;
  assign next_feedback = wr_fbk ? hwdata[8:0] : feedback;

  assign status_word = ({29'h0, cur_source} << osp_pkg::STAT_SRC_LSB)
                     | ({30'h0, cur_pmode} << osp_pkg::STAT_PMODE_LSB)
                     | ({31'h0, second_pin_is_io} << osp_pkg::STAT_PIN_BIT)
                     | ({31'h0, pll_active} << osp_pkg::STAT_PLL_BIT);

  always_comb begin
    next_rdata = 32'h0;
    case (rd_addr)
      osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR: begin
        next_rdata = ({29'h0, next_clock_divisor_register.rc_postscaler_field} << osp_pkg::RCPOST_LSB)
                   | ({30'h0, next_clock_divisor_register.vco_output_postscaler_field} << osp_pkg::VCOPOST_LSB)
                   | ({27'h0, next_clock_divisor_register.vco_input_prescaler_field} << osp_pkg::PRE_LSB);
      end
      osp_pkg::FEEDBACK_ADDR: begin
        next_rdata = {23'h0, next_feedback};
      end
      osp_pkg::STATUS_ADDR: begin
        next_rdata = status_word;
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      hrdata   <= 32'h0;
      clock_divisor_register   <= '{osp_pkg::RCPOST_RESET, osp_pkg::VCOPOST_RESET, osp_pkg::PRE_RESET};
      feedback <= osp_pkg::FEEDBACK_RESET;
    end else begin
      wr_pend  <= addr_ok && hwrite;
      wr_addr  <= haddr[7:0];
      clock_divisor_register   <= next_clock_divisor_register;
      feedback <= next_feedback;
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // source decode
  // ----------------------------------------------------------------
  wire src_primary = (cur_source == osp_pkg::OSP_SRC_PRIMARY)
                   || (cur_source == osp_pkg::OSP_SRC_PRIMARY_PLL);
  wire src_pll     = (cur_source == osp_pkg::OSP_SRC_PRIMARY_PLL)
                   || (cur_source == osp_pkg::OSP_SRC_RC_PLL);
  wire src_rc      = (cur_source == osp_pkg::OSP_SRC_FAST_RC)
                   || (cur_source == osp_pkg::OSP_SRC_RC_PLL)
                   || (cur_source == osp_pkg::OSP_SRC_RC_DIV16)
                   || (cur_source == osp_pkg::OSP_SRC_RC_DIVN);

  assign fast_crystal_drive     = src_primary && (cur_pmode == osp_pkg::OSP_PM_FAST); // R3
  assign standard_crystal_drive = src_primary && (cur_pmode == osp_pkg::OSP_PM_STANDARD); // R3
  assign external_clock_input   = src_primary && (cur_pmode == osp_pkg::OSP_PM_EXTERNAL); // R3
  assign pll_active             = src_pll;
  assign second_pin_is_io       = pin_fn && (src_rc || (cur_source == osp_pkg::OSP_SRC_SLOW_RC)
                                  || external_clock_input);                       // R17
  assign wdt_ref_tick           = slow_tick;                                      // R16

  // ----------------------------------------------------------------
  // rc postscaler
  // ----------------------------------------------------------------
  logic [8:0] rc_factor;
  logic [8:0] rc_cnt;

  always_comb begin
    rc_factor = 9'h001;
    case (clock_divisor_register.rc_postscaler_field)                                 // R20
      3'h0:    rc_factor = 9'h001;
      3'h1:    rc_factor = 9'h002;
      3'h2:    rc_factor = 9'h004;
      3'h3:    rc_factor = 9'h008;
      3'h4:    rc_factor = 9'h010;
      3'h5:    rc_factor = 9'h020;
      3'h6:    rc_factor = 9'h040;
      default: rc_factor = 9'h100;
    endcase
    if (cur_source == osp_pkg::OSP_SRC_RC_DIV16) begin
      rc_factor = osp_pkg::RC_DIV16;                                  // R2
    end
  end

  wire rc_div_tick = rc_tick && (rc_cnt >= rc_factor - 9'h001);       // R7

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_cnt <= 9'h000;
    end else if (rc_tick) begin
      rc_cnt <= rc_div_tick ? 9'h000 : rc_cnt + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // pll rate model: fout = fin * m / (n1 * n2)
  // ----------------------------------------------------------------
  logic [3:0]  post_factor;
  logic [11:0] pll_acc;

  always_comb begin
    post_factor = 4'h4;
    case (clock_divisor_register.vco_output_postscaler_field)                         // R10 R18
      2'h0:    post_factor = 4'h2;
      2'h1:    post_factor = 4'h4;
      2'h3:    post_factor = 4'h8;
      default: post_factor = 4'h4;
    endcase
  end

  wire [5:0]  pre_factor = {1'b0, clock_divisor_register.vco_input_prescaler_field}
                         + osp_pkg::PRE_OFFSET;                                   // R8 R19
  wire [9:0]  fb_factor  = {1'b0, feedback} + osp_pkg::FEEDBACK_OFFSET;           // R9
  wire [11:0] div_prod   = {6'h00, pre_factor} * {8'h00, post_factor};            // R11
  wire        pll_in     = (cur_source == osp_pkg::OSP_SRC_RC_PLL) ? rc_tick : prim_tick; // R15
  wire        pll_tick   = (pll_acc >= div_prod);
  wire        acc_room   = (pll_acc < 12'hc00);
  wire [11:0] acc_add    = (pll_in && acc_room) ? {2'h0, fb_factor} : 12'h000;
  wire [11:0] acc_sub    = pll_tick ? div_prod : 12'h000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_acc <= 12'h000;
    end else if (!src_pll) begin
      pll_acc <= 12'h000;
    end else begin
      pll_acc <= pll_acc + acc_add - acc_sub;                         // R11
    end
  end

  // ----------------------------------------------------------------
  // oscillator select and fosc/2
  // ----------------------------------------------------------------
  logic next_osc;
  logic half_phase;

  always_comb begin
    next_osc = 1'b0;
    case (cur_source)                                                 // R2
      osp_pkg::OSP_SRC_FAST_RC:     next_osc = rc_tick;
      osp_pkg::OSP_SRC_RC_PLL:      next_osc = pll_tick;
      osp_pkg::OSP_SRC_PRIMARY:     next_osc = prim_tick;
      osp_pkg::OSP_SRC_PRIMARY_PLL: next_osc = pll_tick;
      osp_pkg::OSP_SRC_SECONDARY:   next_osc = sec_tick;              // R15
      osp_pkg::OSP_SRC_SLOW_RC:     next_osc = slow_tick;             // R15
      osp_pkg::OSP_SRC_RC_DIV16:    next_osc = rc_div_tick;
      osp_pkg::OSP_SRC_RC_DIVN:     next_osc = rc_div_tick;
      default:             next_osc = rc_tick;
    endcase
  end

  // one instruction tick per two oscillator ticks, at most hclk/2 = 50 MIPS
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_tick             <= 1'b0;
      half_phase           <= 1'b0;
      instr_tick           <= 1'b0;
      peripheral_time_base <= 1'b0;
    end else begin
      osc_tick             <= next_osc;
      if (next_osc) begin
        half_phase <= half_phase + 1'b1;
      end
      instr_tick           <= next_osc && half_phase;                 // R5 R6
      peripheral_time_base <= next_osc && half_phase;                 // R5
    end
  end

endmodule

/* verif/osp_clock_select_checker.sv */
// Purpose: port assertions for osp_clock_select
// Assumes: straps change only while reset is held
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module osp_clock_select_checker (
  input wire logic       hclk,                    // clock
  input wire logic       hresetn,                 // reset, active low
  input wire logic [2:0] initial_source_select,   // strap
  input wire logic [1:0] primary_mode_select,     // strap
  input wire logic       second_pin_function_bit, // strap
  input wire logic       slow_internal_rc,        // slow rc level
  input wire logic       instr_tick,              // instruction enable
  input wire logic       peripheral_time_base,    // peripheral enable
  input wire logic       wdt_ref_tick,            // slow rc reference
  input wire logic       fast_crystal_drive,      // fast crystal on
  input wire logic       standard_crystal_drive,  // crystal on
  input wire logic       external_clock_input,    // clock input on
  input wire logic       second_pin_is_io,        // pin as i/o
  input wire logic       pll_active               // pll in path
);
  logic      straps_live;
  wire logic prim = (initial_source_select[2:1] == 2'h1);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // high from the first edge after release, the same edge that latches the straps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      straps_live <= 1'b0;
    end else begin
      straps_live <= 1'b1;
    end
  end

  pll_path_a: assert property (straps_live |-> pll_active ==
    (!initial_source_select[2] && initial_source_select[0])) else $error("pll path flag wrong");
  fast_drive_a: assert property (straps_live |-> fast_crystal_drive ==
    (prim && primary_mode_select == 2'h2)) else $error("fast crystal drive wrong");
  std_drive_a: assert property (straps_live |-> standard_crystal_drive ==
    (prim && primary_mode_select == 2'h1)) else $error("crystal drive wrong");
  ext_input_a: assert property (straps_live |-> external_clock_input ==
    (prim && primary_mode_select == 2'h0)) else $error("clock input select wrong");
  pin_func_a: assert property (straps_live |-> second_pin_is_io ==
    (second_pin_function_bit && (initial_source_select[2:1] == 2'h0
    || initial_source_select > 3'h4 || prim && primary_mode_select == 2'h0)))
    else $error("second pin function wrong");
  tick_pair_a: assert property (instr_tick == peripheral_time_base)
    else $error("instruction and peripheral ticks differ");
  instr_gap_a: assert property (instr_tick |=> !instr_tick)
    else $error("instruction tick on back to back cycles");
  wdt_ref_a: assert property ($rose(slow_internal_rc) |-> ##[1:5] wdt_ref_tick)
    else $error("reference tick missing");
endmodule

bind osp_clock_select osp_clock_select_checker u_osp_clock_select_checker (
  .hclk, .hresetn, .initial_source_select, .primary_mode_select, .second_pin_function_bit,
  .slow_internal_rc,
  .instr_tick, .peripheral_time_base, .wdt_ref_tick, .fast_crystal_drive,
  .standard_crystal_drive, .external_clock_input, .second_pin_is_io, .pll_active
);

/* verif/osp_osc_model.sv */
// Purpose: oscillator sources seen by the clock select block
// Assumes: half periods in hclk cycles, each at least 2
// Notes:   primary stands low while no driver or input is enabled
`timescale 1ns/1ps
module osp_osc_model #(
  parameter int FAST_HALF = 3,
  parameter int PRI_HALF  = 4,
  parameter int SEC_HALF  = 7,
  parameter int SLOW_HALF = 9
) (
  input  wire logic       hclk,        // system clock
  input  wire logic       primary_en,  // crystal driver or clock input on
  output logic      [3:0] osc          // slow, secondary, primary, fast rc
);
  int         half [4] = '{FAST_HALF, PRI_HALF, SEC_HALF, SLOW_HALF};
  int         cnt  [4] = '{0, 0, 0, 0};
  logic [3:0] lvl      = 4'h0;
  assign osc = lvl;
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (i == 1 && !primary_en) begin
        lvl[i] <= 1'b0;
        cnt[i] <= 0;
      end else if (cnt[i] >= half[i] - 1) begin
        lvl[i] <= ~lvl[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

/* verif/testbench.sv */
// Purpose: self-checking bench for osp_clock_select
// Assumes: straps change only while reset is held
// Notes:   rates are judged by counting ticks over a fixed window
`timescale 1ns/1ps
module testbench;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [2:0]  src     = 3'h7;
  logic [1:0]  pmode   = 2'h3;
  logic        pin_bit = 1'b1;
  logic [3:0]  osc_q   = 4'h0;
  wire  logic [31:0] hrdata;
  wire  logic [3:0]  osc;
  wire  logic        hreadyout, osc_tick, instr_tick, ptb, wdt_tick, fdrv, sdrv, ext;
  int          err_total = 0;
  int          checked   = 0;
  int          n_osc = 0, n_ins = 0, n_wdt = 0;
  int          n_edge [4] = '{0, 0, 0, 0};

  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    osc_q <= osc;
    n_osc <= n_osc + int'(osc_tick);
    n_ins <= n_ins + int'(instr_tick);
    n_wdt <= n_wdt + int'(wdt_tick);
    for (int i = 0; i < 4; i++) n_edge[i] <= n_edge[i] + int'(osc[i] & ~osc_q[i]);
  end

  osp_clock_select u_osp_clock_select (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
    .initial_source_select(src), .primary_mode_select(pmode), .second_pin_function_bit(pin_bit),
    .fast_internal_rc(osc[0]), .primary_osc(osc[1]), .secondary_crystal(osc[2]),
    .slow_internal_rc(osc[3]), .osc_tick, .instr_tick, .peripheral_time_base(ptb),
    .wdt_ref_tick(wdt_tick), .fast_crystal_drive(fdrv), .standard_crystal_drive(sdrv),
    .external_clock_input(ext), .second_pin_is_io(), .pll_active()
  );
  osp_osc_model u_osp_osc_model (.hclk, .primary_en(fdrv | sdrv | ext), .osc);

  task automatic cmp(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic cmp_rate(string name, int g, int src_n, int num, int den);
    int d;
    d = g * den - src_n * num;
    checked++;
    if (d > 2 * den || d < -2 * den) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", name, src_n * num / den, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask
  task automatic rd_chk(string name, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    cmp(name, e, v & m);
  endtask
  task automatic restart(logic [2:0] s, logic [1:0] p);
    @(posedge hclk);
    hresetn <= 1'b0;
    src     <= s;
    pmode   <= p;
    pin_bit <= !(s[0] && p[0]);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  task automatic rate(string name, int k, int num, int den);
    int o, i, w, e, s;
    o = n_osc;
    i = n_ins;
    w = n_wdt;
    e = n_edge[k];
    s = n_edge[3];
    repeat (2400) @(posedge hclk);
    cmp_rate(name, n_osc - o, n_edge[k] - e, num, den);
    cmp_rate("instr tick", n_ins - i, n_osc - o, 1, 2);
    cmp_rate("wdt ref tick", n_wdt - w, n_edge[3] - s, 1, 1);
  endtask

  task automatic t_regs();
    restart(3'h0, 2'h0);
    rd_chk("clock_divisor_register reset", osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR, '1, 32'h40);
    rd_chk("feedback reset", osp_pkg::FEEDBACK_ADDR, '1, 32'h0);
    wr(osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR, '1);
    rd_chk("clock_divisor_register fields", osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR, '1, 32'h7df);
    wr(osp_pkg::FEEDBACK_ADDR, '1);
    rd_chk("feedback field", osp_pkg::FEEDBACK_ADDR, '1, 32'h1ff);
    wr(osp_pkg::STATUS_ADDR, '1);
    rd_chk("status read only", osp_pkg::STATUS_ADDR, 32'hffffffef, 32'h0);
    wr(8'h0c, '1);
    rd_chk("unmapped", 8'h0c, '1, 32'h0);
    $display("register test done");
  endtask
  task automatic t_modes();
    logic [31:0] e;
    for (int s = 0; s < 8; s++) begin
      for (int p = 0; p < 3; p++) begin
        restart(3'(s), 2'(p));
        e = (32'(s) << osp_pkg::STAT_SRC_LSB) | (32'(p) << osp_pkg::STAT_PMODE_LSB);
        e = e | (32'(s == 1 || s == 3) << osp_pkg::STAT_PLL_BIT);
        e = e | (32'(((s & p & 1) == 0) && (s < 2 || s > 4 || (s / 2 == 1 && p == 0)))
            << osp_pkg::STAT_PIN_BIT);
        rd_chk("status", osp_pkg::STATUS_ADDR, '1, e);
      end
    end
    $display("mode test done");
  endtask
  task automatic t_divn();
    restart(3'h7, 2'h3);
    for (int k = 0; k < 8; k++) begin
      wr(osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR, 32'(k) << osp_pkg::RCPOST_LSB);
      rate("rc divide", 0, 1, (k == 7) ? 256 : (1 << k));
    end
    restart(3'h6, 2'h3);
    rate("rc by sixteen", 0, 1, 16);
    $display("divider test done");
  endtask
  task automatic t_paths();
    logic [2:0]  s  [9] = '{3'h1, 3'h1, 3'h1, 3'h3, 3'h2, 3'h2, 3'h2, 3'h4, 3'h5};
    logic [1:0]  p  [9] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
    logic [31:0] cd [9] = '{32'h0, 32'h41, 32'hdf, 32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'h40};
    logic [31:0] fb [9] = '{32'h2, 32'h16, 32'h106, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int          k  [9] = '{0, 0, 0, 1, 1, 1, 1, 2, 3};
    int          nm [9] = '{4, 24, 264, 2, 1, 1, 1, 1, 1};
    int          dn [9] = '{4, 12, 264, 8, 1, 1, 1, 1, 1};
    for (int j = 0; j < 9; j++) begin
      restart(s[j], p[j]);
      wr(osp_pkg::CLOCK_DIVISOR_REGISTER_ADDR, cd[j]);
      wr(osp_pkg::FEEDBACK_ADDR, fb[j]);
      rate("clock path", k[j], nm[j], dn[j]);
    end
    $display("clock path test done");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge hclk);
    err_total++;
    conclude();
  end
  initial begin
    t_regs();
    t_modes();
    t_divn();
    t_paths();
    conclude();
  end
endmodule
